/* verilog/ccda_regs.svh */
// register offsets, fields, resets and counts of the context and agu block
// assumes byte addressing on a 32-bit avalon-mm slave
// Functional notes
// - sixteen 16-bit general working registers
// - last register is the stack pointer
// - two alternate sets, first fifteen only
// - interrupt level selects alternate set persistently
// - swap instruction changes active set
// - status shows current and manual set
// - 23-bit program counter
// - 24-bit instruction words, 16-bit data
// - most instructions one cycle, some longer
// - do loops stay interruptible; repeat stalls fetch until its count ends
// - 16K-word data space, X and Y
// - general instructions use X generator only
// - dual operand fetch uses X and Y
// - upper 32 KB window onto program space
// - page registers extend data address
// - modulo wrap in X and Y
// - X modulo usable by general instructions
// - X generator bit-reversed sequencing
`ifndef CCDA_REGS_SVH
`define CCDA_REGS_SVH
`define CCDA_OFS_ALT_CFG 8'h00
`define CCDA_OFS_CTX_STAT 8'h04
`define CCDA_OFS_RD_PAGE 8'h08
`define CCDA_OFS_WR_PAGE 8'h0c
`define CCDA_OFS_PSV 8'h10
`define CCDA_OFS_XMOD_START 8'h14
`define CCDA_OFS_XMOD_END 8'h18
`define CCDA_OFS_YMOD_START 8'h1c
`define CCDA_OFS_YMOD_END 8'h20
`define CCDA_OFS_MOD_CTRL 8'h24
`define CCDA_OFS_PC 8'h28
`define CCDA_ALT1_LSB 0
`define CCDA_ALT2_LSB 4
`define CCDA_PSV_EN_BIT 15
`define CCDA_MODX_BIT 0
`define CCDA_MODY_BIT 1
`define CCDA_BREV_BIT 2
`define CCDA_RST_ALT_CFG 16'h0000
`define CCDA_RST_PAGE 9'h001
`define CCDA_PC_STEP 23'h000002
`define CCDA_PTR_STEP 16'h0002
`define CCDA_LONG_CYCLES 2'h1
`endif

/* verilog/ccda_pkg.sv */
// types shared by the context and agu block
// assumes ccda_regs.svh carries the numbers
package ccda_pkg;
    typedef enum logic [1:0] {
        CCDA_BUS_IDLE = 2'b01,
        CCDA_BUS_ACK = 2'b10
    } ccda_bus_state_type;
    typedef struct packed {
        logic [15:0] addr;
        logic modulo;
        logic bitrev;
        logic wr;
    } ccda_agu_req_type;
    typedef struct packed {
        logic [23:0] addr;
        logic prog;
    } ccda_ext_addr_type;
endpackage : ccda_pkg

/* verilog/ccda_core.sv */
// working registers, context sets, program counter and data address generators
// assumes decoder and memory on the same clock; registers over avalon-mm
`timescale 1ns/1ps
`include "ccda_regs.svh"
module ccda_core #(
    parameter logic [15:0] XY_BOUNDARY = 16'h1000
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [3:0] i_rd_a_idx,
    input wire logic [3:0] i_rd_b_idx,
    output logic [15:0] o_rd_a_data,
    output logic [15:0] o_rd_b_data,
    input wire logic i_wr_en,
    input wire logic [3:0] i_wr_idx,
    input wire logic [15:0] i_wr_data,
    input wire logic i_sp_push,
    input wire logic i_sp_pop,
    input wire logic i_irq_enter,
    input wire logic [2:0] i_irq_level,
    input wire logic i_irq_exit,
    input wire logic [1:0] i_irq_prev_ctx,
    input wire logic i_ctx_swap,
    input wire logic [1:0] i_swap_ctx,
    input wire logic i_pc_load,
    input wire logic [22:0] i_pc_target,
    input wire logic [23:0] i_instr_word,
    input wire logic i_instr_long,
    input wire logic i_repeat_start,
    input wire logic [13:0] i_repeat_count,
    input wire logic i_do_start,
    input wire logic [13:0] i_do_count,
    input wire logic [22:0] i_do_end,
    output logic [22:0] o_fetch_addr,
    output logic [23:0] o_instr,
    output logic o_stall,
    input wire logic i_x_valid,
    input wire ccda_pkg::ccda_agu_req_type i_x_req,
    input wire logic i_y_valid,
    input wire ccda_pkg::ccda_agu_req_type i_y_req,
    output ccda_pkg::ccda_ext_addr_type o_x_ext,
    output logic [15:0] o_x_next_ptr,
    output logic [15:0] o_y_addr,
    output logic [15:0] o_y_next_ptr,
    output logic o_y_region_fault
);
    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic [5:0] slot(input logic [1:0] ctx, input logic [3:0] idx);
        slot = 6'(ctx * 15 + idx);
    endfunction : slot

    function automatic logic [15:0] mod_next(input logic [15:0] p, input logic [15:0] s,
                                             input logic [15:0] e);
        mod_next = (p[15:1] >= e[15:1]) ? s : 16'(p + `CCDA_PTR_STEP);
    endfunction : mod_next

    function automatic logic [15:0] rev16(input logic [15:0] v);
        for (int k = 0; k < 16; k++) begin
            rev16[k] = v[15 - k];
        end
    endfunction : rev16

    function automatic ccda_pkg::ccda_ext_addr_type ext_addr(input logic [15:0] ea,
            input logic [8:0] page, input logic psv_en, input logic [8:0] psv_page);
        ext_addr.prog = 1'b0;
        ext_addr.addr = {8'h00, ea};
        if (ea[15]) begin
            ext_addr.prog = psv_en;
            ext_addr.addr = psv_en ? {psv_page, ea[14:0]} : {page, ea[14:0]};
        end
    endfunction : ext_addr

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    logic [15:0] alt_register_config_word;
    logic [8:0] data_read_page;
    logic [8:0] data_write_page;
    logic [15:0] psv_ctrl;
    logic [15:0] xmod_start;
    logic [15:0] xmod_end;
    logic [15:0] ymod_start;
    logic [15:0] ymod_end;
    logic [2:0] mod_ctrl;
    logic [15:0] brev_modifier;
    logic [1:0] current_context_index;
    logic [1:0] manual_context_index;
    logic [22:0] pc;
    ccda_pkg::ccda_bus_state_type bus_state;
    logic req;
    logic wr_hit;
    logic [15:0] wdata;
    logic [31:0] next_rdata;

    assign req = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & (bus_state != ccda_pkg::CCDA_BUS_ACK);
    assign wr_hit = i_avs_write & (bus_state == ccda_pkg::CCDA_BUS_ACK);
    assign wdata = {i_avs_byteenable[1] ? i_avs_writedata[15:8] : 8'h00,
                    i_avs_byteenable[0] ? i_avs_writedata[7:0] : 8'h00};

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus_state <= ccda_pkg::CCDA_BUS_IDLE;
        end else begin
            case (bus_state)
                ccda_pkg::CCDA_BUS_IDLE: begin
                    if (req) begin
                        bus_state <= ccda_pkg::CCDA_BUS_ACK;
                    end
                end
                ccda_pkg::CCDA_BUS_ACK: begin
                    bus_state <= ccda_pkg::CCDA_BUS_IDLE;
                end
                default: begin
                    bus_state <= ccda_pkg::CCDA_BUS_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        next_rdata = 32'h00000000;
        case (i_avs_address)
            `CCDA_OFS_ALT_CFG: next_rdata = {16'h0000, alt_register_config_word};
            `CCDA_OFS_CTX_STAT: next_rdata = {24'h000000, 2'h0,
                                              manual_context_index, 2'h0, current_context_index};
            `CCDA_OFS_RD_PAGE: next_rdata = {23'h000000, data_read_page};
            `CCDA_OFS_WR_PAGE: next_rdata = {23'h000000, data_write_page};
            `CCDA_OFS_PSV: next_rdata = {16'h0000, psv_ctrl};
            `CCDA_OFS_XMOD_START: next_rdata = {16'h0000, xmod_start};
            `CCDA_OFS_XMOD_END: next_rdata = {16'h0000, xmod_end};
            `CCDA_OFS_YMOD_START: next_rdata = {16'h0000, ymod_start};
            `CCDA_OFS_YMOD_END: next_rdata = {16'h0000, ymod_end};
            `CCDA_OFS_MOD_CTRL: next_rdata = {brev_modifier, 13'h0000, mod_ctrl};
            `CCDA_OFS_PC: next_rdata = {9'h000, pc};
            default: next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_readdata <= 32'h00000000;
        end else if (i_avs_read && bus_state == ccda_pkg::CCDA_BUS_IDLE) begin
            o_avs_readdata <= next_rdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            alt_register_config_word <= `CCDA_RST_ALT_CFG;
            data_read_page <= `CCDA_RST_PAGE;
            data_write_page <= `CCDA_RST_PAGE;
            psv_ctrl <= 16'h0000;
            xmod_start <= 16'h0000;
            xmod_end <= 16'h0000;
            ymod_start <= 16'h0000;
            ymod_end <= 16'h0000;
            mod_ctrl <= 3'h0;
            brev_modifier <= 16'h0000;
        end else if (wr_hit) begin
            case (i_avs_address)
                `CCDA_OFS_ALT_CFG: alt_register_config_word <= wdata & 16'h0077;
                `CCDA_OFS_RD_PAGE: data_read_page <= wdata[8:0];
                `CCDA_OFS_WR_PAGE: data_write_page <= wdata[8:0];
                `CCDA_OFS_PSV: psv_ctrl <= wdata & 16'h81ff;
                `CCDA_OFS_XMOD_START: xmod_start <= wdata;
                `CCDA_OFS_XMOD_END: xmod_end <= wdata;
                `CCDA_OFS_YMOD_START: ymod_start <= wdata;
                `CCDA_OFS_YMOD_END: ymod_end <= wdata;
                `CCDA_OFS_MOD_CTRL: begin
                    mod_ctrl <= wdata[2:0];
                    brev_modifier <= {i_avs_byteenable[3] ? i_avs_writedata[31:24] : 8'h00,
                                      i_avs_byteenable[2] ? i_avs_writedata[23:16] : 8'h00};
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // context selection
    // ----------------------------------------
    logic [2:0] alt1_level;
    logic [2:0] alt2_level;
    assign alt1_level = alt_register_config_word[`CCDA_ALT1_LSB +: 3];
    assign alt2_level = alt_register_config_word[`CCDA_ALT2_LSB +: 3];

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            current_context_index <= 2'h0;
            manual_context_index <= 2'h0;
        end else if (i_irq_enter && i_irq_level != 3'h0 && i_irq_level != 3'h7) begin
            if (i_irq_level == alt1_level) begin
                current_context_index <= 2'h1;
            end else if (i_irq_level == alt2_level) begin
                current_context_index <= 2'h2;
            end
        end else if (i_irq_exit && i_irq_prev_ctx != 2'h3) begin
            current_context_index <= i_irq_prev_ctx;
        end else if (i_ctx_swap && i_swap_ctx != 2'h3) begin
            current_context_index <= i_swap_ctx;
            manual_context_index <= i_swap_ctx;
        end
    end

    // ----------------------------------------
    // working registers and stack pointer
    // ----------------------------------------
    logic [15:0] wreg [0:44];
    logic [15:0] software_stack_pointer;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int k = 0; k < 45; k++) begin
                wreg[k] <= 16'h0000;
            end
        end else if (i_wr_en && i_wr_idx != 4'hf) begin
            wreg[slot(current_context_index, i_wr_idx)] <= i_wr_data;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            software_stack_pointer <= 16'h0000;
        end else if (i_wr_en && i_wr_idx == 4'hf) begin
            software_stack_pointer <= i_wr_data;
        end else if (i_sp_push) begin
            software_stack_pointer <= 16'(software_stack_pointer + `CCDA_PTR_STEP);
        end else if (i_sp_pop) begin
            software_stack_pointer <= 16'(software_stack_pointer - `CCDA_PTR_STEP);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_a_data <= 16'h0000;
            o_rd_b_data <= 16'h0000;
        end else begin
            o_rd_a_data <= (i_rd_a_idx == 4'hf) ? software_stack_pointer :
                           wreg[slot(current_context_index, i_rd_a_idx)];
            o_rd_b_data <= (i_rd_b_idx == 4'hf) ? software_stack_pointer :
                           wreg[slot(current_context_index, i_rd_b_idx)];
        end
    end

    // ----------------------------------------
    // program counter, fetch and loops
    // ----------------------------------------
    logic [1:0] long_cnt;
    logic [13:0] repeat_cnt;
    logic [13:0] do_cnt;
    logic [22:0] do_top;
    logic [22:0] do_last;
    assign o_stall = (long_cnt != 2'h0) | (repeat_cnt != 14'h0000);
    assign o_fetch_addr = pc;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            long_cnt <= 2'h0;
        end else if (long_cnt != 2'h0) begin
            long_cnt <= 2'(long_cnt - 2'h1);
        end else if (i_instr_long) begin
            long_cnt <= `CCDA_LONG_CYCLES;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            repeat_cnt <= 14'h0000;
        end else if (i_repeat_start) begin
            repeat_cnt <= i_repeat_count;
        end else if (repeat_cnt != 14'h0000 && long_cnt == 2'h0) begin
            repeat_cnt <= 14'(repeat_cnt - 14'h0001);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            do_cnt <= 14'h0000;
            do_top <= 23'h000000;
            do_last <= 23'h000000;
        end else if (i_do_start) begin
            do_cnt <= i_do_count;
            do_top <= 23'(pc + `CCDA_PC_STEP);
            do_last <= i_do_end;
        end else if (!o_stall && !i_pc_load && pc == do_last && do_cnt != 14'h0000) begin
            do_cnt <= 14'(do_cnt - 14'h0001);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pc <= 23'h000000;
        end else if (i_pc_load) begin
            pc <= {i_pc_target[22:1], 1'b0};
        end else if (!o_stall) begin
            if (pc == do_last && do_cnt != 14'h0000) begin
                pc <= do_top;
            end else begin
                pc <= 23'(pc + `CCDA_PC_STEP);
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_instr <= 24'h000000;
        end else if (!o_stall) begin
            o_instr <= i_instr_word;
        end
    end

    // ----------------------------------------
    // x and y address generators
    // ----------------------------------------
    logic [15:0] x_step;
    logic [15:0] y_step;
    always_comb begin
        x_step = 16'(i_x_req.addr + `CCDA_PTR_STEP);
        if (i_x_req.bitrev && mod_ctrl[`CCDA_BREV_BIT]) begin
            x_step = rev16(16'(rev16(i_x_req.addr) + rev16(brev_modifier)));
        end else if (i_x_req.modulo && mod_ctrl[`CCDA_MODX_BIT]) begin
            x_step = mod_next(i_x_req.addr, xmod_start, xmod_end);
        end
        y_step = 16'(i_y_req.addr + `CCDA_PTR_STEP);
        if (i_y_req.modulo && mod_ctrl[`CCDA_MODY_BIT]) begin
            y_step = mod_next(i_y_req.addr, ymod_start, ymod_end);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_x_ext <= '0;
            o_x_next_ptr <= 16'h0000;
        end else if (i_x_valid) begin
            o_x_ext <= ext_addr(i_x_req.addr,
                                i_x_req.wr ? data_write_page : data_read_page,
                                psv_ctrl[`CCDA_PSV_EN_BIT] & ~i_x_req.wr, psv_ctrl[8:0]);
            o_x_next_ptr <= x_step;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_y_addr <= 16'h0000;
            o_y_next_ptr <= 16'h0000;
            o_y_region_fault <= 1'b0;
        end else if (i_y_valid) begin
            o_y_addr <= i_y_req.addr;
            o_y_next_ptr <= y_step;
            o_y_region_fault <= (i_y_req.addr < XY_BOUNDARY) | i_y_req.addr[15];
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_sp_push_step: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_sp_push && !i_wr_en |=> software_stack_pointer == $past(software_stack_pointer) + 16'h2)
        else $error("stack pointer push step wrong");
    a_irq_alt_one: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_irq_enter && i_irq_level == alt1_level && i_irq_level inside {[3'h1:3'h6]}
        |=> current_context_index == 2'h1) else $error("alt set not taken on irq");
    a_ctx_persist: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_irq_enter && !i_irq_exit && !i_ctx_swap |=> $stable(current_context_index))
        else $error("context changed without cause");
    a_swap_manual: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_ctx_swap && !i_irq_enter && !i_irq_exit && i_swap_ctx != 2'h3
        |=> current_context_index == $past(i_swap_ctx)
        && manual_context_index == $past(i_swap_ctx)) else $error("swap mismatch");
    a_pc_advance: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_pc_load && !o_stall && !(pc == do_last && do_cnt != 14'h0) |=> pc == $past(pc) + 23'h2)
        else $error("pc did not advance");
    a_long_stall: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_instr_long && long_cnt == 2'h0 |=> o_stall) else $error("long instr no stall");
    a_repeat_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_repeat_start && i_repeat_count == 14'h2 && !i_pc_load
        ##1 (!i_pc_load && !i_repeat_start)[*2] |=> pc == $past(pc, 2))
        else $error("pc moved during repeat");
    a_xmod_wrap: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_x_valid && i_x_req.modulo && !i_x_req.bitrev && mod_ctrl[0] && i_x_req.addr == xmod_end
        |=> o_x_next_ptr == xmod_start) else $error("x modulo wrap missed");
    a_psv_map: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_x_valid && !i_x_req.wr && i_x_req.addr[15] && psv_ctrl[15] && !wr_hit
        |=> o_x_ext.prog && o_x_ext.addr[23:15] == psv_ctrl[8:0])
        else $error("psv mapping wrong");
    a_bus_one_wait: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        $rose(req) |-> o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("bus wait wrong");
    c_swap: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) i_ctx_swap);
    c_irq_alt2: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_irq_enter ##1 current_context_index == 2'h2);
    c_do_loop: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        pc == do_last && do_cnt != 14'h0 && !o_stall);
    c_bus_read: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_avs_read && !o_avs_waitrequest);
endmodule : ccda_core

/* verif/ccda_exec_model.sv */
// instruction source standing in for program memory and execution unit
// assumes the core fetches every cycle from o_fetch_addr
`timescale 1ns/1ps
module ccda_exec_model (
    input wire logic [22:0] i_fetch_addr,
    output logic [23:0] o_instr_word
);
    // ----------------------------------------
    // word follows the fetch address
    // ----------------------------------------
    assign o_instr_word = {1'b1, i_fetch_addr} ^ 24'h5a0000;
endmodule : ccda_exec_model

/* verif/tb_top.sv */
// bench for the context and agu core
// assumes 50 ns clock, async low reset held 8 cycles
`timescale 1ns/1ps
`include "ccda_regs.svh"
module tb_top;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0, wr = 1'b0;
    logic [31:0] wd = 32'h0, rdata, q;
    logic wt;
    logic [3:0] ia = 4'h0, ib = 4'h0, wi = 4'h0;
    logic [15:0] da, db, wdat = 16'h0, xn, ya, yn;
    logic we = 1'b0, push = 1'b0, pop = 1'b0, ent = 1'b0, ext = 1'b0, swp = 1'b0;
    logic [2:0] lvl = 3'h0;
    logic [1:0] cx = 2'h0;
    logic pld = 1'b0, lng = 1'b0, rps = 1'b0, dos = 1'b0, stl, yf, xv = 1'b0, yv = 1'b0;
    logic [22:0] ptg = 23'h0, dend = 23'h0, fa;
    logic [13:0] rpc = 14'h0, doc = 14'h0;
    logic [23:0] iw, ins;
    ccda_pkg::ccda_agu_req_type xr = '0, yr = '0;
    ccda_pkg::ccda_ext_addr_type xe;
    int fail_count = 0;
    int n_tests = 0;
    always #25 i_sys_clk = ~i_sys_clk;
    ccda_exec_model partner (.i_fetch_addr(fa), .o_instr_word(iw));
    ccda_core #(.XY_BOUNDARY(16'h1000)) dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(4'hf),
        .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wt),
        .i_rd_a_idx(ia), .i_rd_b_idx(ib), .o_rd_a_data(da), .o_rd_b_data(db), .i_wr_en(we),
        .i_wr_idx(wi), .i_wr_data(wdat), .i_sp_push(push), .i_sp_pop(pop), .i_irq_enter(ent),
        .i_irq_level(lvl), .i_irq_exit(ext), .i_irq_prev_ctx(cx), .i_ctx_swap(swp),
        .i_swap_ctx(cx), .i_pc_load(pld), .i_pc_target(ptg), .i_instr_word(iw),
        .i_instr_long(lng), .i_repeat_start(rps), .i_repeat_count(rpc), .i_do_start(dos),
        .i_do_count(doc), .i_do_end(dend), .o_fetch_addr(fa), .o_instr(ins),
        .o_stall(stl), .i_x_valid(xv), .i_x_req(xr), .i_y_valid(yv), .i_y_req(yr),
        .o_x_ext(xe), .o_x_next_ptr(xn), .o_y_addr(ya), .o_y_next_ptr(yn),
        .o_y_region_fault(yf));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic avs(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic busy;
        @(posedge i_sys_clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        busy = 1'b1;
        n = 0;
        while (busy && n < 20) begin
            @(posedge i_sys_clk);
            busy = (wt !== 1'b0);
            n++;
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (busy) fail_count++;
    endtask : avs
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        avs(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rchk
    task automatic wreg(input logic [3:0] i, input logic [15:0] d);
        @(posedge i_sys_clk);
        we <= 1'b1;
        wi <= i;
        wdat <= d;
        @(posedge i_sys_clk);
        we <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [3:0] i, input logic [15:0] e);
        @(posedge i_sys_clk);
        ia <= i;
        ib <= i;
        @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        chk({16'h0, da}, {16'h0, e});
        chk({16'h0, db}, {16'h0, e});
    endtask : rreg
    task automatic ctl(input logic [2:0] k, input logic [2:0] l, input logic [1:0] c);
        @(posedge i_sys_clk);
        {swp, ext, ent} <= k;
        lvl <= l;
        cx <= c;
        @(posedge i_sys_clk);
        {swp, ext, ent} <= 3'b000;
    endtask : ctl
    task automatic agu(input ccda_pkg::ccda_agu_req_type x, input ccda_pkg::ccda_agu_req_type y);
        @(posedge i_sys_clk);
        xv <= 1'b1;
        yv <= 1'b1;
        xr <= x;
        yr <= y;
        @(posedge i_sys_clk);
        xv <= 1'b0;
        yv <= 1'b0;
        @(negedge i_sys_clk);
    endtask : agu
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        rchk(`CCDA_OFS_RD_PAGE, 32'h1);
        rchk(`CCDA_OFS_WR_PAGE, 32'h1);
        rchk(8'h3c, 32'h0);
        avs(1'b1, `CCDA_OFS_ALT_CFG, 32'h0021);
        rchk(`CCDA_OFS_ALT_CFG, 32'h21);
        avs(1'b1, `CCDA_OFS_CTX_STAT, 32'h33);
        rchk(`CCDA_OFS_CTX_STAT, 32'h0);
        wreg(4'h3, 16'h1234);
        wreg(4'hf, 16'h0800);
        rreg(4'h3, 16'h1234);
        ctl(3'b100, 3'h0, 2'h1);
        wreg(4'h3, 16'h5678);
        rreg(4'hf, 16'h0800);
        @(posedge i_sys_clk) push <= 1'b1;
        @(posedge i_sys_clk) push <= 1'b0;
        rreg(4'hf, 16'h0802);
        @(posedge i_sys_clk) pop <= 1'b1;
        @(posedge i_sys_clk) pop <= 1'b0;
        rreg(4'hf, 16'h0800);
        rchk(`CCDA_OFS_CTX_STAT, 32'h11);
        ctl(3'b100, 3'h0, 2'h0);
        rreg(4'h3, 16'h1234);
        ctl(3'b001, 3'h2, 2'h0);
        rchk(`CCDA_OFS_CTX_STAT, 32'h02);
        wreg(4'h3, 16'hbeef);
        ctl(3'b001, 3'h7, 2'h0);
        rreg(4'h3, 16'hbeef);
        ctl(3'b010, 3'h0, 2'h0);
        rreg(4'h3, 16'h1234);
        ctl(3'b001, 3'h1, 2'h0);
        rreg(4'h3, 16'h5678);
        @(posedge i_sys_clk) begin
            pld <= 1'b1;
            ptg <= 23'h7ffffe;
        end
        @(posedge i_sys_clk) pld <= 1'b0;
        @(negedge i_sys_clk) chk({9'h0, fa}, 32'h7ffffe);
        @(negedge i_sys_clk) chk({9'h0, fa}, 32'h0);
        chk({8'h0, ins}, 32'h00a5fffe);
        @(posedge i_sys_clk) lng <= 1'b1;
        @(posedge i_sys_clk) lng <= 1'b0;
        @(negedge i_sys_clk) chk({8'h0, stl, fa}, {9'h1, 23'h4});
        @(negedge i_sys_clk) chk({9'h0, fa}, 32'h4);
        chk({8'h0, ins}, 32'h00da0002);
        @(negedge i_sys_clk) chk({9'h0, fa}, 32'h6);
        @(posedge i_sys_clk) begin
            rps <= 1'b1;
            rpc <= 14'h2;
        end
        @(posedge i_sys_clk) rps <= 1'b0;
        @(negedge i_sys_clk) chk({8'h0, stl, fa}, {9'h1, 23'ha});
        repeat (2) @(negedge i_sys_clk);
        chk({8'h0, stl, fa}, {9'h0, 23'ha});
        @(negedge i_sys_clk) chk({9'h0, fa}, 32'hc);
        @(posedge i_sys_clk) begin
            dos <= 1'b1;
            doc <= 14'h1;
            dend <= 23'h12;
        end
        @(posedge i_sys_clk) dos <= 1'b0;
        repeat (3) @(negedge i_sys_clk);
        chk({9'h0, fa}, 32'h10);
        repeat (2) @(negedge i_sys_clk);
        chk({9'h0, fa}, 32'h14);
        agu('{16'h0100, 1'b0, 1'b0, 1'b0}, '{16'h0100, 1'b0, 1'b0, 1'b0});
        chk({7'h0, xe}, {7'h0, 24'h000100, 1'b0});
        chk({16'h0, xn}, 32'h0102);
        chk({31'h0, yf}, 32'h1);
        agu('{16'h8010, 1'b0, 1'b0, 1'b0}, '{16'h1100, 1'b0, 1'b0, 1'b0});
        chk({6'h0, xe, yf}, {6'h0, 24'h008010, 2'b00});
        chk({ya, yn}, 32'h11001102);
        avs(1'b1, `CCDA_OFS_WR_PAGE, 32'h5);
        agu('{16'h8010, 1'b0, 1'b0, 1'b1}, '{16'h1100, 1'b0, 1'b0, 1'b0});
        chk({7'h0, xe}, {8'h02, 16'h8010, 1'b0});
        avs(1'b1, `CCDA_OFS_PSV, 32'h8003);
        agu('{16'h8010, 1'b0, 1'b0, 1'b0}, '{16'h1100, 1'b0, 1'b0, 1'b0});
        chk({7'h0, xe}, {8'h01, 16'h8010, 1'b1});
        avs(1'b1, `CCDA_OFS_XMOD_START, 32'h0200);
        avs(1'b1, `CCDA_OFS_XMOD_END, 32'h0206);
        avs(1'b1, `CCDA_OFS_YMOD_START, 32'h1200);
        avs(1'b1, `CCDA_OFS_YMOD_END, 32'h1204);
        avs(1'b1, `CCDA_OFS_MOD_CTRL, 32'h00080007);
        agu('{16'h0206, 1'b1, 1'b0, 1'b0}, '{16'h1204, 1'b1, 1'b0, 1'b0});
        chk({xn, yn}, 32'h02001200);
        agu('{16'h0202, 1'b1, 1'b0, 1'b0}, '{16'h1202, 1'b1, 1'b0, 1'b0});
        chk({xn, yn}, 32'h02041204);
        agu('{16'h0008, 1'b0, 1'b1, 1'b0}, '{16'h1100, 1'b0, 1'b0, 1'b0});
        chk({16'h0, xn}, 32'h0004);
        agu('{16'h0000, 1'b0, 1'b1, 1'b0}, '{16'h1100, 1'b0, 1'b0, 1'b0});
        chk({16'h0, xn}, 32'h0008);
        summarize();
    end
    initial begin
        repeat (3000) @(posedge i_sys_clk);
        fail_count++;
        summarize();
    end
endmodule : tb_top
